// ===== testbench/sor_chk_checker.sv
// sor_chk: port assertions for the sync output stage
// assumes a bind onto sor_sync_out; input sync polarity left at reset
module sor_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic [7:0] reg_wdata,
  // sync pins
  input wire logic horizontal_sync_input,
  input wire logic vsync_input,
  input wire logic green_sync_input,
  input wire logic regen_hsync_out,
  input wire logic green_sync_slicer_out,
  input wire logic odd_even_field,
  input wire logic vertical_sync_out,
  input wire logic vertical_sync_oe_n,
  input wire logic slave_addr_lsb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rel; // edges since reset release
  logic [1:0] sel; // shadow of slicer select
  logic [7:0] wid; // shadow of hsync width
  logic [7:0] vctl; // shadow of vsync control
  logic [7:0] run; // cycles hsync out active
  wire src = sel[0] ? horizontal_sync_input : green_sync_input;
  // shadows track writes so the checks need no peek inside
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rel <= 3'h0;
      sel <= 2'h0;
      wid <= 8'h20;
      vctl <= 8'h84;
      run <= 8'h00;
    end else begin
      rel <= (rel == 3'h7) ? rel : rel + 3'h1;
      run <= regen_hsync_out ? run + 8'h01 : 8'h00;
      if (reg_we && reg_addr == 8'h1d) sel <= reg_wdata[1:0];
      if (reg_we && reg_addr == 8'h13) wid <= reg_wdata;
      if (reg_we && reg_addr == 8'h14) vctl <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_oe_hold; rel < 3'h4 |-> vertical_sync_oe_n; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin driven early");
  property p_oe_drv; rel == 3'h7 |-> !vertical_sync_oe_n; endproperty
  a_oe_drv: assert property (p_oe_drv) else $error("pin not driven");
  // the bit is latched on the edge that turns the driver on, so look one edge later
  property p_strap; $past(!vertical_sync_oe_n) |-> $stable(slave_addr_lsb); endproperty
  a_strap: assert property (p_strap) else $error("address bit moved");
  property p_sog; (!sel[1] && $stable(src) && $stable(sel))[*5]
    |-> green_sync_slicer_out == src; endproperty
  a_sog: assert property (p_sog) else $error("slicer source wrong");
  property p_hs_lat; $rose(horizontal_sync_input) |-> ##[2:6] regen_hsync_out; endproperty
  a_hs_lat: assert property (p_hs_lat) else $error("hsync out late");
  property p_hs_wid; $fell(regen_hsync_out) |-> run == wid; endproperty
  a_hs_wid: assert property (p_hs_wid) else $error("hsync width wrong");
  property p_vs; (vctl == 8'h34 && $stable(vsync_input))[*6]
    |-> vertical_sync_out == vsync_input; endproperty
  a_vs: assert property (p_vs) else $error("vsync pass wrong");
  property p_fld; $changed(odd_even_field) |=> $stable(odd_even_field)[*8]; endproperty
  a_fld: assert property (p_fld) else $error("field flag unsteady");
  cover property ($fell(regen_hsync_out));
  cover property ($changed(odd_even_field));
  cover property (sel == 2'h1 && green_sync_slicer_out);
endmodule // sor_chk

// ===== testbench/sor_sync_out_tb.sv
// sor_sync_out_tb: scenario bench for the sync output stage
// assumes a pull-up on the shared pin and sor_vid_src on the sync pins
module sor_sync_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_we = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic run = 1'b0;
  logic f1;
  logic [7:0] ex; // expected slicer level
  wire [7:0] reg_rdata;
  wire hs, vs, sog, regen, slc, fld, vso, oe_n, lsb;
  wire pin = oe_n ? 1'b1 : vso; // pull-up while undriven
  int failures = 0;
  int checks_done = 0;
  int n;
  always #2.5 clk = ~clk;
  sor_vid_src i_sor_vid_src (.run(run), .lclk(), .hs(hs), .vs(vs), .sog(sog));
  sor_sync_out i_sor_sync_out (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .horizontal_sync_input(hs), .vsync_input(vs), .composite_sync_input(~vs),
    .green_sync_input(sog), .regen_hsync_out(regen), .green_sync_slicer_out(slc),
    .odd_even_field(fld), .slave_addr_lsb_pin_in(pin), .vertical_sync_out(vso),
    .vertical_sync_oe_n(oe_n), .slave_addr_lsb(lsb));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task step; @(posedge clk); #1; endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // bounded wait for a low-to-high change: 0 hs, 1 vs, 2 regen
  task rise(input int k);
    n = 0;
    while ((k == 0 ? hs : k == 1 ? vs : regen) !== 1'b0 && n < 9000) begin step; n++; end
    while ((k == 0 ? hs : k == 1 ? vs : regen) !== 1'b1 && n < 9000) begin step; n++; end
    if (n >= 9000) chk("wait", 8'h00, 8'h01);
  endtask
  task t_strap;
    repeat (6) step;
    chk("addr_lsb", 8'h01, {7'h00, lsb});
    chk("oe_n", 8'h00, {7'h00, oe_n});
  endtask
  task t_regs;
    rd(8'h15, 8'h04);
    rd(8'h13, 8'h20);
    wr(8'h15, 8'ha5);
    rd(8'h15, 8'ha5);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
  endtask
  task t_hs;
    wr(8'h13, 8'h08);
    run <= 1'b1;
    rise(2);
    n = 0;
    while (regen === 1'b1 && n < 99) begin n++; step; end
    chk("hs_width", 8'h08, n[7:0]);
  endtask
  task t_sog;
    for (int s = 0; s < 4; s++) begin
      wr(8'h1d, s[7:0]);
      rd(8'h1d, s[7:0]);
      rise(0);
      repeat (8) step;
      // regenerated and filtered hsync are both active this early in the pulse
      ex = (s == 0) ? {7'h00, sog} : (s == 1) ? {7'h00, hs} : 8'h01;
      chk("slicer", ex, {7'h00, slc});
    end
  endtask
  task t_vs;
    rise(1);
    repeat (6) step;
    chk("vs_sep_early", 8'h00, {7'h00, vso});
    repeat (300) step;
    chk("vs_sep", 8'h01, {7'h00, vso});
    wr(8'h14, 8'h34);
    rise(1);
    repeat (6) step;
    chk("vs_out", 8'h01, {7'h00, vso});
    wr(8'h14, 8'h30);
    repeat (6) step;
    chk("vs_out_low", 8'h00, {7'h00, vso});
    wr(8'h14, 8'h34);
  endtask
  task t_field;
    rise(1);
    repeat (20) step;
    f1 = fld;
    rise(1);
    repeat (20) step;
    chk("field", {7'h00, ~f1}, {7'h00, fld});
  endtask
  // override: pulse spans two hsync leading edges, well past the source pulse
  task t_vs_ovr;
    wr(8'h15, 8'h02);
    wr(8'h14, 8'h36);
    rise(1);
    repeat (600) step;
    chk("vs_ovr_on", 8'h01, {7'h00, vso});
    repeat (500) step;
    chk("vs_ovr_off", 8'h00, {7'h00, vso});
  endtask
  task final_report;
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_strap;
    t_regs;
    t_hs;
    t_sog;
    t_vs;
    t_field;
    t_vs_ovr;
    final_report;
  end
  // hang guard: the run needs roughly 105 us
  initial begin
    #400000;
    failures++;
    final_report;
  end
endmodule // sor_sync_out_tb
bind sor_sync_out sor_chk i_sor_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_we(reg_we), .reg_wdata(reg_wdata), .horizontal_sync_input(horizontal_sync_input),
  .vsync_input(vsync_input), .green_sync_input(green_sync_input),
  .regen_hsync_out(regen_hsync_out), .green_sync_slicer_out(green_sync_slicer_out),
  .odd_even_field(odd_even_field), .vertical_sync_out(vertical_sync_out),
  .vertical_sync_oe_n(vertical_sync_oe_n), .slave_addr_lsb(slave_addr_lsb));

// ===== testbench/sor_vid_src.sv
// sor_vid_src: video timing source for the sync pins
// assumes run rises once; the link clock stands still while run is low
module sor_vid_src (
  input wire logic run,
  output logic lclk,
  output logic hs,
  output logic vs,
  output logic sog
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt = 7'h22; // tick in an 8-line frame of 16-tick lines
  logic fld = 1'b0; // vsync start shifts half a line per frame
  logic [6:0] dv; // ticks since vsync start
  initial lclk = 1'b0;
  always #80 if (run) lclk = ~lclk;
  always @(posedge lclk) begin
    cnt <= cnt + 7'h01;
    if (cnt == 7'h7f) fld <= ~fld;
  end
  assign dv = cnt - (fld ? 7'h09 : 7'h01);
  assign hs = cnt[3:0] < 4'h2;
  assign vs = dv < 7'h10;
  assign sog = hs ^ vs;
endmodule // sor_vid_src

// ===== verilog/sor_map.vh
// sync output routing: register offsets, field positions, reset values
// assumes inclusion by the sync output routing design files only
`ifndef SOR_MAP_VH
`define SOR_MAP_VH

// register offsets
`define SOR_HS_CTRL_ADDR 8'h12
`define SOR_HS_WIDTH_ADDR 8'h13
`define SOR_VS_CTRL_ADDR 8'h14
`define SOR_VS_DUR_ADDR 8'h15
`define SOR_STATUS_ADDR 8'h16
`define SOR_SOG_CTRL_ADDR 8'h1d

// hsync control fields
`define SOR_HS_OUT_POL_BIT 7
`define SOR_HS_IN_POL_BIT 6

// vsync control fields
`define SOR_VS_OVR_BIT 1
`define SOR_VS_OUT_POL_BIT 2
`define SOR_VS_SEP_BIT 7
`define SOR_VS_IN_POL_HI 5
`define SOR_VS_IN_POL_LO 4

// status fields
`define SOR_ST_FIELD_BIT 0
`define SOR_ST_VPOL_BIT 1
`define SOR_ST_ADDR_BIT 2

// reset values
`define SOR_HS_CTRL_RST 8'hc0
`define SOR_HS_WIDTH_RST 8'h20
`define SOR_VS_CTRL_RST 8'h84
`define SOR_VS_DUR_RST 8'h04
`define SOR_SOG_CTRL_RST 2'h0

// timing counts in clk cycles
`define SOR_STRAP_WAIT 3'h4
`define SOR_CSYNC_VS_MIN 16'h0100
`define SOR_HS_FILT_LEN 4'h4

`endif

// ===== verilog/sor_sync2.v
// sor_sync2: two flip-flop synchroniser for a bus of level inputs
// assumes the inputs are asynchronous to clk; only the second stage is read
module sor_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // async in, synced out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta; // first stage, read only by sync_out

  // plain two-stage capture
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sor_sync2

// ===== verilog/sor_sync_out.v
// sor_sync_out: sync output stage (hsync regen, vsync out, slicer mux, field flag)
// assumes registers arrive from the serial control port on clk; sync pins are async
// Overview of operation
// - regenerate hsync out, retimed to sample clock
// - hsync out polarity and width programmable
// - hsync out aligned with data clock edge
// - vsync out separated or passed through
// - control bit selects vsync output polarity
// - override bit uses programmed vsync duration
// - address pin supplies slave address lsb
// - latch address pin at power-up, pull-up reads 1
// - address and vsync roles do not interfere
// - 2-bit field picks one of four slicer sources
// - slicer output otherwise unprocessed
// - vsync extraction done in sync separator
// - field flag shows odd or even field
// - sliced sync shown non-inverted on slicer output
// - vsync input polarity automatic or manual
`include "sor_map.vh"
module sor_sync_out #(
  parameter CW = 16 // width of line and pulse measurement counters
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register port from the serial control port
  input wire [7:0] reg_addr,
  input wire reg_we,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // sync inputs, asynchronous
  input wire horizontal_sync_input,
  input wire vsync_input,
  input wire composite_sync_input,
  input wire green_sync_input,
  // sync outputs
  output reg regen_hsync_out,
  output reg green_sync_slicer_out,
  output reg odd_even_field,
  // shared vsync / address pin
  input wire slave_addr_lsb_pin_in,
  output reg vertical_sync_out,
  output reg vertical_sync_oe_n,
  output reg slave_addr_lsb
);

  // configuration registers
  reg [7:0] hs_ctrl;
  reg [7:0] hs_width;
  reg [7:0] vs_ctrl;
  reg [7:0] vsync_out_duration;
  reg [1:0] sog_ctrl;

  // synchronised pins and their previous values for edge finding
  wire [4:0] pins_s;
  reg [4:0] pins_d;
  wire hs_raw = pins_s[0];
  wire vs_raw = pins_s[1];
  wire cs_raw = pins_s[2];
  wire sog_raw = pins_s[3];
  wire a0_raw = pins_s[4];

  sor_sync2 #(.W(5)) i_sor_sync2 (
    .clk(clk),
    .rstn(rstn),
    .async_in({slave_addr_lsb_pin_in, green_sync_input, composite_sync_input,
               vsync_input, horizontal_sync_input}),
    .sync_out(pins_s)
  );

  // register writes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_ctrl <= `SOR_HS_CTRL_RST;
      hs_width <= `SOR_HS_WIDTH_RST;
      vs_ctrl <= `SOR_VS_CTRL_RST;
      vsync_out_duration <= `SOR_VS_DUR_RST;
      sog_ctrl <= `SOR_SOG_CTRL_RST;
    end else if (reg_we) begin
      case (reg_addr)
        `SOR_HS_CTRL_ADDR: hs_ctrl <= reg_wdata;
        `SOR_HS_WIDTH_ADDR: hs_width <= reg_wdata;
        `SOR_VS_CTRL_ADDR: vs_ctrl <= reg_wdata;
        `SOR_VS_DUR_ADDR: vsync_out_duration <= reg_wdata;
        `SOR_SOG_CTRL_ADDR: sog_ctrl <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // edge history of the synced pins
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      pins_d <= 5'h00;
    else
      pins_d <= pins_s;
  end

  // hsync normalised to active high by the input polarity bit
  wire hs_act = hs_raw ^ ~hs_ctrl[`SOR_HS_IN_POL_BIT];
  wire hs_lead = hs_act & ~(pins_d[0] ^ ~hs_ctrl[`SOR_HS_IN_POL_BIT]);

  // hsync regeneration: fixed-width pulse from each leading edge
  reg [7:0] hs_cnt;
  reg hs_regen;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_cnt <= 8'h00;
      hs_regen <= 1'b0;
    end else if (hs_lead && hs_width != 8'h00) begin
      hs_cnt <= hs_width - 8'h01;
      hs_regen <= 1'b1;
    end else if (hs_cnt != 8'h00) begin
      hs_cnt <= hs_cnt - 8'h01;
    end else begin
      hs_regen <= 1'b0;
    end
  end

  // registered output so hsync leaves on the same edge as the data
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      regen_hsync_out <= 1'b0;
    else
      regen_hsync_out <= hs_regen ^ ~hs_ctrl[`SOR_HS_OUT_POL_BIT];
  end

  // hsync glitch filter: a level must hold a few cycles to pass
  reg [3:0] filt_cnt;
  reg hs_filt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_cnt <= 4'h0;
      hs_filt <= 1'b0;
    end else if (hs_act == hs_filt) begin
      filt_cnt <= 4'h0;
    end else if (filt_cnt == `SOR_HS_FILT_LEN - 4'h1) begin
      hs_filt <= hs_act;
      filt_cnt <= 4'h0;
    end else begin
      filt_cnt <= filt_cnt + 4'h1;
    end
  end

  // slicer mux; registered so a select change cannot glitch the pin
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      green_sync_slicer_out <= 1'b0;
    end else begin
      case (sog_ctrl)
        2'h0: green_sync_slicer_out <= sog_raw;
        2'h1: green_sync_slicer_out <= hs_raw;
        2'h2: green_sync_slicer_out <= hs_regen;
        2'h3: green_sync_slicer_out <= hs_filt;
        default: green_sync_slicer_out <= sog_raw;
      endcase
    end
  end

  // vsync auto polarity: the shorter level is the active one
  reg [CW-1:0] lvl_cnt;
  reg [CW-1:0] hi_len;
  reg [CW-1:0] lo_len;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_cnt <= {CW{1'b0}};
      hi_len <= {CW{1'b0}};
      lo_len <= {CW{1'b0}};
    end else if (vs_raw != pins_d[1]) begin
      lvl_cnt <= {CW{1'b0}};
      if (pins_d[1])
        hi_len <= lvl_cnt;
      else
        lo_len <= lvl_cnt;
    end else if (lvl_cnt != {CW{1'b1}}) begin
      lvl_cnt <= lvl_cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  wire auto_pol_hi = hi_len < lo_len;
  // manual field: 2'b0x auto, 2'b10 active low, 2'b11 active high
  wire vs_pol_hi = vs_ctrl[`SOR_VS_IN_POL_HI] ? vs_ctrl[`SOR_VS_IN_POL_LO]
                                               : auto_pol_hi;
  wire vs_pass = vs_raw ^ ~vs_pol_hi;

  // sync separator: composite sync active (low) for long enough is vsync
  reg [15:0] cs_cnt;
  reg vs_sep;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_cnt <= 16'h0000;
      vs_sep <= 1'b0;
    end else if (cs_raw) begin
      cs_cnt <= 16'h0000;
      vs_sep <= 1'b0;
    end else if (cs_cnt == `SOR_CSYNC_VS_MIN) begin
      vs_sep <= 1'b1;
    end else begin
      cs_cnt <= cs_cnt + 16'h0001;
    end
  end

  // vsync source and its leading edge
  wire vs_src = vs_ctrl[`SOR_VS_SEP_BIT] ? vs_sep : vs_pass;
  reg vs_src_d;
  wire vs_lead = vs_src & ~vs_src_d;

  // override: pulse lasting a programmed number of hsync periods
  reg [7:0] vs_lines;
  reg vs_ovr;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vs_src_d <= 1'b0;
      vs_lines <= 8'h00;
      vs_ovr <= 1'b0;
    end else begin
      vs_src_d <= vs_src;
      if (vs_lead && vsync_out_duration != 8'h00) begin
        vs_lines <= vsync_out_duration;
        vs_ovr <= 1'b1;
      end else if (vs_ovr && hs_lead) begin
        vs_lines <= vs_lines - 8'h01;
        if (vs_lines == 8'h01)
          vs_ovr <= 1'b0;
      end
    end
  end

  wire vs_act = vs_ctrl[`SOR_VS_OVR_BIT] ? vs_ovr : vs_src;

  // field detect: vsync past mid-line marks the odd field
  reg [CW-1:0] line_pos;
  reg [CW-1:0] line_len;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_pos <= {CW{1'b0}};
      line_len <= {CW{1'b0}};
      odd_even_field <= 1'b0;
    end else begin
      if (hs_lead) begin
        line_pos <= {CW{1'b0}};
        line_len <= line_pos;
      end else if (line_pos != {CW{1'b1}}) begin
        line_pos <= line_pos + {{(CW-1){1'b0}}, 1'b1};
      end
      if (vs_lead)
        odd_even_field <= line_pos > {1'b0, line_len[CW-1:1]};
    end
  end

  // strap capture: pin undriven after reset, sampled once, then vsync drives
  reg [2:0] strap_cnt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt <= 3'h0;
      slave_addr_lsb <= 1'b1;
      vertical_sync_oe_n <= 1'b1;
      vertical_sync_out <= 1'b0;
    end else begin
      if (strap_cnt != `SOR_STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 3'h1;
        if (strap_cnt == `SOR_STRAP_WAIT - 3'h1) begin
          slave_addr_lsb <= a0_raw;
          vertical_sync_oe_n <= 1'b0;
        end
      end
      vertical_sync_out <= vs_act ^ ~vs_ctrl[`SOR_VS_OUT_POL_BIT];
    end
  end

  // register readback
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `SOR_HS_CTRL_ADDR: reg_rdata <= hs_ctrl;
        `SOR_HS_WIDTH_ADDR: reg_rdata <= hs_width;
        `SOR_VS_CTRL_ADDR: reg_rdata <= vs_ctrl;
        `SOR_VS_DUR_ADDR: reg_rdata <= vsync_out_duration;
        `SOR_STATUS_ADDR: reg_rdata <= {5'h00, slave_addr_lsb, vs_pol_hi, odd_even_field};
        `SOR_SOG_CTRL_ADDR: reg_rdata <= {6'h00, sog_ctrl};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // sor_sync_out
